/* File: include/slsf_params.svh */
// Offsets, field positions, reset values and counts of the link status block
`ifndef SLSF_PARAMS_SVH
`define SLSF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------------------
`define SLSF_ADDR_W             12
`define SLSF_ADDR_LINK_STATUS   12'h06c
`define SLSF_ADDR_CTRL          12'h070

// ----------------------------------------------------------------------------
// Field positions of link_status
// ----------------------------------------------------------------------------
`define SLSF_BIT_LINK_UP        6
`define SLSF_BIT_SYNC_IDLE      5
`define SLSF_BIT_PHASE_SHIFT    4
`define SLSF_BIT_SYSREF_SEEN    3
`define SLSF_BIT_PLL_LOCK       2
`define SLSF_BIT_CAL_DONE       1
`define SLSF_BIT_CLK_PRESENT    0

// ----------------------------------------------------------------------------
// Field positions and reset value of the control register
// ----------------------------------------------------------------------------
`define SLSF_BIT_SYSREF_DET_EN  0
`define SLSF_CTRL_RESET         1'h0

// ----------------------------------------------------------------------------
// Synchroniser lanes and counts
// ----------------------------------------------------------------------------
`define SLSF_SYNC_W             4
`define SLSF_LANE_SYNC_REQ_N    0
`define SLSF_LANE_SYSREF        1
`define SLSF_LANE_PLL_LOCK      2
`define SLSF_LANE_CLK_PRESENT   3
`define SLSF_MIN_REQ_FRAMES     3'h4
`define SLSF_FRAME_CNT_W        3

`endif

/* File: include/slsf_pkg.sv */
// Types shared by the link status block
`include "slsf_params.svh"

package slsf_pkg;

	// Link bring-up sequence as seen by the status logic
	typedef enum logic [2:0] {
		SLSF_IDLE = 3'b000,
		SLSF_REQ  = 3'b001,
		SLSF_SYNC = 3'b010,
		SLSF_ILA  = 3'b011,
		SLSF_DATA = 3'b100
	} slsf_link_state_t;

	// Two-stage synchroniser state
	typedef struct packed {
		logic [`SLSF_SYNC_W-1:0] stage1;
		logic [`SLSF_SYNC_W-1:0] stage2;
	} slsf_sync_state_t;

	// Whole state of the status block
	typedef struct packed {
		slsf_link_state_t             st;
		logic [`SLSF_FRAME_CNT_W-1:0] frame_cnt;
		logic                         sysref_q;
		logic                         phase_shift;
		logic                         sysref_seen;
		logic                         sysref_detect_enable;
		logic [31:0]                  prdata;
		logic                         pslverr;
	} slsf_state_t;

endpackage

/* File: rtl/slsf_link_status.sv */
// Serial link status register with APB access
//
// Function
// - Link-up reads 1 only after sync finished, the lane alignment sequence was sent and data is valid.
// - Sync-idle reads 0 from a sync request until sync is done, and 1 when no sync is requested.
// - Sync-idle follows the sync sequence state, not the momentary sync request pin.
// - Phase-shift is set when a sysref event moves the frame or multiframe clock phase.
// - Phase-shift is left alone by sysref events that move no clock phase.
// - Phase-shift is sticky and clears when software writes 1 to its bit.
// - Sysref-seen is set once a sysref event has been processed and the clocks follow it.
// - Sysref-seen is set on a rising sysref edge.
// - Sysref-seen clears when software writes 1 to its bit.
// - Both phase-shift and sysref-seen clear when the input clock present flag goes low.
// - The PLL lock bit reads 1 when locked and 0 when unlocked.
// - The calibration done bit reads 1 once calibration completes, else 0.
// - The clock present bit reads 1 when an active sampling clock is detected, else 0.
// - The link status register sits at address 0x006c with no defined reset value.
`timescale 1ns/1ns
`default_nettype none
`include "slsf_params.svh"

module slsf_link_status (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_n,
	// APB slave
	input  wire logic                    i_psel,
	input  wire logic                    i_penable,
	input  wire logic                    i_pwrite,
	input  wire logic [`SLSF_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]             i_pwdata,
	output logic      [31:0]             o_prdata,
	output logic                         o_pready,
	output logic                         o_pslverr,
	// Pins from the far end and the analog side
	input  wire logic                    i_sync_req_n,
	input  wire logic                    i_sysref,
	input  wire logic                    i_pll_lock,
	input  wire logic                    i_clk_present,
	// Internal sources on the core clock
	input  wire logic                    i_cal_done,
	input  wire logic                    i_frame_tick,
	input  wire logic                    i_phase_moved,
	input  wire logic                    i_ila_done,
	input  wire logic                    i_data_valid,
	// Control out to the framer
	output logic                         o_sysref_detect_enable
);

	// ------------------------------------------------------------------------
	// Synchronised pin levels
	// ------------------------------------------------------------------------
	logic [`SLSF_SYNC_W-1:0] pins_s;
	logic                    sync_req_n_s;
	logic                    sysref_s;
	logic                    pll_lock_s;
	logic                    clk_present_s;

	slsf_sync2 u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_async    ({i_clk_present, i_pll_lock, i_sysref, !i_sync_req_n}),
		.o_sync     (pins_s)
	);

	// Request lane travels inverted so a stage cleared by reset means no request
	assign sync_req_n_s  = !pins_s[`SLSF_LANE_SYNC_REQ_N];
	assign sysref_s      = pins_s[`SLSF_LANE_SYSREF];
	assign pll_lock_s    = pins_s[`SLSF_LANE_PLL_LOCK];
	assign clk_present_s = pins_s[`SLSF_LANE_CLK_PRESENT];

	// ------------------------------------------------------------------------
	// State and decoded bus strobes
	// ------------------------------------------------------------------------
	slsf_pkg::slsf_state_t s;
	slsf_pkg::slsf_state_t next_s;

	logic       setup;
	logic       access_wr;
	logic       hit_status;
	logic       hit_ctrl;
	logic       link_up;
	logic       sync_idle;
	logic       sysref_evt;
	logic       phase_evt;
	logic       clr_phase;
	logic       clr_seen;
	logic [7:0] status_val;

	// Zero wait states: every access phase completes at its first edge
	assign o_pready   = 1'b1;
	assign setup      = i_psel && !i_penable;
	assign access_wr  = i_psel && i_penable && i_pwrite;
	assign hit_status = (i_paddr == `SLSF_ADDR_LINK_STATUS);
	assign hit_ctrl   = (i_paddr == `SLSF_ADDR_CTRL);

	// Link-up needs the sequence finished and live data behind it
	assign link_up = (s.st == slsf_pkg::SLSF_DATA) && i_data_valid;

	// Flag tracks the sequence, so a short pin glitch in IDLE is not hidden
	assign sync_idle = (s.st != slsf_pkg::SLSF_REQ)
		&& (s.st != slsf_pkg::SLSF_SYNC);

	// Sysref processing only with detection enabled and a live sampling clock
	assign sysref_evt = sysref_s && !s.sysref_q && s.sysref_detect_enable
		&& clk_present_s;
	assign phase_evt  = i_phase_moved && s.sysref_detect_enable
		&& clk_present_s;

	// One-to-clear strobes; a zero leaves the flag alone
	assign clr_phase = access_wr && hit_status && i_pwdata[`SLSF_BIT_PHASE_SHIFT];
	assign clr_seen  = access_wr && hit_status && i_pwdata[`SLSF_BIT_SYSREF_SEEN];

	// Status word as software sees it; bit 7 reads zero
	always_comb begin
		status_val                        = 8'h00;
		status_val[`SLSF_BIT_LINK_UP]     = link_up;
		status_val[`SLSF_BIT_SYNC_IDLE]   = sync_idle;
		status_val[`SLSF_BIT_PHASE_SHIFT] = s.phase_shift;
		status_val[`SLSF_BIT_SYSREF_SEEN] = s.sysref_seen;
		status_val[`SLSF_BIT_PLL_LOCK]    = pll_lock_s;
		status_val[`SLSF_BIT_CAL_DONE]    = i_cal_done;
		status_val[`SLSF_BIT_CLK_PRESENT] = clk_present_s;
	end

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		next_s          = s;
		next_s.sysref_q = sysref_s;

		// Bring-up sequence; a lost sampling clock drops the link at once
		unique case (s.st)
			slsf_pkg::SLSF_IDLE: begin
				if (!sync_req_n_s) begin
					next_s.st        = slsf_pkg::SLSF_REQ;
					next_s.frame_cnt = '0;
				end
			end
			slsf_pkg::SLSF_REQ: begin
				// Too short a request is dropped, matching the receiver's duty
				if (sync_req_n_s) begin
					next_s.st = slsf_pkg::SLSF_IDLE;
				end else if (i_frame_tick) begin
					if (s.frame_cnt == `SLSF_MIN_REQ_FRAMES - 3'h1) begin
						next_s.st = slsf_pkg::SLSF_SYNC;
					end
					next_s.frame_cnt = s.frame_cnt + 3'h1;
				end
			end
			slsf_pkg::SLSF_SYNC: begin
				if (sync_req_n_s) begin
					next_s.st = slsf_pkg::SLSF_ILA;
				end
			end
			slsf_pkg::SLSF_ILA: begin
				if (!sync_req_n_s) begin
					next_s.st        = slsf_pkg::SLSF_REQ;
					next_s.frame_cnt = '0;
				end else if (i_ila_done) begin
					next_s.st = slsf_pkg::SLSF_DATA;
				end
			end
			slsf_pkg::SLSF_DATA: begin
				if (!sync_req_n_s) begin
					next_s.st        = slsf_pkg::SLSF_REQ;
					next_s.frame_cnt = '0;
				end
			end
			default: begin
				next_s.st = slsf_pkg::SLSF_IDLE;
			end
		endcase
		if (!clk_present_s) begin
			next_s.st = slsf_pkg::SLSF_IDLE;
		end

		// Sticky flags: the set beats a same-cycle software clear
		if (clr_phase) begin
			next_s.phase_shift = 1'b0;
		end
		if (phase_evt) begin
			next_s.phase_shift = 1'b1;
		end
		if (clr_seen) begin
			next_s.sysref_seen = 1'b0;
		end
		if (sysref_evt) begin
			next_s.sysref_seen = 1'b1;
		end
		// No clock means no valid alignment to report
		if (!clk_present_s) begin
			next_s.phase_shift = 1'b0;
			next_s.sysref_seen = 1'b0;
		end

		// Control write; software must see calibration done first
		if (access_wr && hit_ctrl) begin
			next_s.sysref_detect_enable = i_pwdata[`SLSF_BIT_SYSREF_DET_EN];
		end

		// Read data captured in setup so it is a flop in the access phase
		if (setup) begin
			next_s.pslverr = !(hit_status || hit_ctrl);
			next_s.prdata  = 32'h0000_0000;
			if (hit_status) begin
				next_s.prdata[7:0] = status_val;
			end else if (hit_ctrl) begin
				next_s.prdata[`SLSF_BIT_SYSREF_DET_EN] = s.sysref_detect_enable;
			end
		end
	end

	// Status flags have no documented reset; zero is used for a clean start
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s                      <= '0;
			s.st                   <= slsf_pkg::SLSF_IDLE;
			s.sysref_detect_enable <= `SLSF_CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign o_prdata               = s.prdata;
	assign o_pslverr              = s.pslverr && i_psel && i_penable;
	assign o_sysref_detect_enable = s.sysref_detect_enable;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence seq_status_read;
		setup && hit_status;
	endsequence

	sequence seq_req_seen;
		(s.st == slsf_pkg::SLSF_IDLE) && !sync_req_n_s && clk_present_s;
	endsequence

	// A read shows link-up exactly when data follows the finished sequence
	chk_link_up_read: assert property (
		seq_status_read |=> o_prdata[`SLSF_BIT_LINK_UP]
			== ($past(s.st) == slsf_pkg::SLSF_DATA && $past(i_data_valid)))
		else $error("link-up bit does not match link state");

	// An arriving request drops sync-idle on the next edge
	chk_sync_idle_drop: assert property (
		seq_req_seen |=> !sync_idle)
		else $error("sync-idle not cleared on request");

	// Sync starts only on the fourth frame tick of a held request
	chk_sync_min_frames: assert property (
		$rose(s.st == slsf_pkg::SLSF_SYNC) |->
			$past(s.frame_cnt) == 3'h3 && $past(i_frame_tick) && !$past(sync_req_n_s))
		else $error("sync entered before four frame ticks");

	// During sync the flag stays low even once the pin is released
	chk_sync_state_flag: assert property (
		(s.st == slsf_pkg::SLSF_SYNC) && sync_req_n_s && clk_present_s
			|-> !sync_idle ##1 sync_idle)
		else $error("sync-idle does not follow sequence state");

	// A phase move sets the flag, even against a clear
	chk_phase_set: assert property (
		phase_evt |=> s.phase_shift)
		else $error("phase-shift not set after phase move");

	// Without a phase move or clear the flag keeps its value
	chk_phase_hold: assert property (
		!phase_evt && !clr_phase && clk_present_s |=> $stable(s.phase_shift))
		else $error("phase-shift changed without cause");

	// Writing one clears the phase flag
	chk_phase_w1c: assert property (
		clr_phase && !phase_evt |=> !s.phase_shift)
		else $error("phase-shift not cleared by write");

	// Rising sysref with detection on sets sysref-seen
	chk_seen_set: assert property (
		$rose(sysref_s) && s.sysref_detect_enable && clk_present_s
			|=> s.sysref_seen)
		else $error("sysref-seen not set on rising sysref");

	// Sysref-seen rises only after a rising sysref edge
	chk_seen_cause: assert property (
		$rose(s.sysref_seen) |-> $past(sysref_s) && !$past(s.sysref_q))
		else $error("sysref-seen set without sysref edge");

	// Writing one clears sysref-seen
	chk_seen_w1c: assert property (
		clr_seen && !sysref_evt |=> !s.sysref_seen)
		else $error("sysref-seen not cleared by write");

	// Losing the sampling clock empties both alignment flags
	chk_clk_loss_clear: assert property (
		!clk_present_s |=> !s.phase_shift && !s.sysref_seen)
		else $error("alignment flags survive clock loss");

	// Read-only levels appear in read data one edge after setup
	chk_level_bits: assert property (
		seq_status_read |=> o_prdata[`SLSF_BIT_PLL_LOCK] == $past(pll_lock_s)
			&& o_prdata[`SLSF_BIT_CAL_DONE] == $past(i_cal_done)
			&& o_prdata[`SLSF_BIT_CLK_PRESENT] == $past(clk_present_s))
		else $error("level bits do not match sources");

	// Unmapped addresses answer with an error and zero data
	chk_unmapped_err: assert property (
		setup && !hit_status && !hit_ctrl |=> o_pslverr && o_prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	// A read leaves every sticky flag untouched
	chk_read_no_effect: assert property (
		seq_status_read ##1 (i_psel && !i_pwrite && !phase_evt && !sysref_evt
			&& clk_present_s) |=> $stable(s.phase_shift) && $stable(s.sysref_seen))
		else $error("read changed a sticky flag");

	// With detection off neither alignment flag may rise
	chk_detect_gate: assert property (
		!s.sysref_detect_enable |=> !$rose(s.sysref_seen) && !$rose(s.phase_shift))
		else $error("alignment flag set while detection disabled");

	// The control bit takes the written value at the access edge
	chk_ctrl_write: assert property (
		access_wr && hit_ctrl
			|=> o_sysref_detect_enable == $past(i_pwdata[`SLSF_BIT_SYSREF_DET_EN]))
		else $error("detect enable not written");

	// A lost sampling clock drops the link and reports no sync in progress
	chk_link_drop_clk: assert property (
		!clk_present_s |=> (s.st == slsf_pkg::SLSF_IDLE) && sync_idle && !link_up)
		else $error("link state survives clock loss");

	// A finished alignment sequence moves the link to data
	chk_ila_to_data: assert property (
		(s.st == slsf_pkg::SLSF_ILA) && sync_req_n_s && i_ila_done && clk_present_s
			|=> s.st == slsf_pkg::SLSF_DATA)
		else $error("alignment end did not reach data state");

endmodule
`default_nettype wire

/* File: rtl/slsf_sync2.sv */
// Two flip-flop synchroniser for the asynchronous status inputs
`timescale 1ns/1ns
`default_nettype none
`include "slsf_params.svh"

module slsf_sync2 (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_n,
	input  wire logic [`SLSF_SYNC_W-1:0] i_async,
	output logic      [`SLSF_SYNC_W-1:0] o_sync
);

	slsf_pkg::slsf_sync_state_t s;
	slsf_pkg::slsf_sync_state_t next_s;

	// First stage feeds only the second stage
	always_comb begin
		next_s        = s;
		next_s.stage1 = i_async;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_sync = s.stage2;

endmodule
`default_nettype wire

/* File: tb/slsf_link_status_tb.sv */
// Self-checking bench of the link status register block
`timescale 1ns/1ns
`default_nettype none
`include "slsf_params.svh"

module slsf_link_status_tb;
	logic                    clk, rst_n, psel, penable, pwrite;
	logic [`SLSF_ADDR_W-1:0] paddr;
	logic [31:0]             pwdata, prdata;
	logic                    pready, pslverr, sync_n, sysref, pll, clkp, cal;
	logic                    ftick, pmove, ila, dval, go, busy, det_en;
	logic [3:0]              frames;
	logic [1:0]              fdiv;
	logic                    e_link, e_idle, e_ps, e_seen;
	logic [33:0]             exp_q[$];
	logic [33:0]             e;
	integer                  fails, checks, seed, i;

	// ------------------------------------------------------------------
	// Clock, frame ticks and instances
	// ------------------------------------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk) begin
		fdiv  <= fdiv + 2'h1;
		ftick <= (fdiv == 2'h3);
	end

	slsf_link_status slsf_link_status_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sync_req_n(sync_n),
		.i_sysref(sysref), .i_pll_lock(pll), .i_clk_present(clkp), .i_cal_done(cal),
		.i_frame_tick(ftick), .i_phase_moved(pmove), .i_ila_done(ila), .i_data_valid(dval),
		.o_sysref_detect_enable(det_en));
	slsf_rx_model slsf_rx_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_frame_tick(ftick),
		.i_go(go), .i_frames(frames), .o_sync_req_n(sync_n), .o_busy(busy));

	// ------------------------------------------------------------------
	// Comparison, scoreboard and closing
	// ------------------------------------------------------------------
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks = checks + 1;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fails = fails + 1;
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Oldest note is taken when an access phase completes
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			compare("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (!e[33]) compare("prdata", e[31:0], prdata);
		end
	end

	// Status word expected from the levels the bench drives
	function automatic logic [31:0] st();
		return {24'h0, 1'b0, e_link, e_idle, e_ps, e_seen, pll, cal, clkp};
	endfunction

	// ------------------------------------------------------------------
	// APB master and stimulus helpers
	// ------------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic err, input logic [31:0] exp);
		exp_q.push_back({wr, err, exp});
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the watchdog ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 1'b0, exp);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0, 32'h0);
		repeat (4) @(posedge clk);
	endtask

	// Sysref held a few cycles so the synchroniser sees its rising edge
	task automatic sysref_event(input logic moved);
		@(posedge clk);
		sysref <= 1'b1;
		pmove  <= moved;
		@(posedge clk);
		pmove  <= 1'b0;
		repeat (3) @(posedge clk);
		sysref <= 1'b0;
		repeat (5) @(posedge clk);
	endtask

	// Returns w edges after the request pin falls, so a read can land inside it
	task automatic request(input logic [3:0] f, input int w);
		@(posedge clk);
		go     <= 1'b1;
		frames <= f;
		@(posedge clk);
		go     <= 1'b0;
		repeat (w) @(posedge clk);
	endtask

	task automatic wait_idle();
		while (busy !== 1'b0) begin
			@(posedge clk);
		end
		repeat (5) @(posedge clk);
	endtask

	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		fails = fails + 1;
		final_report();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		sysref = 0; pll = 1; clkp = 1; cal = 0; pmove = 0; ila = 0; dval = 0; go = 0;
		frames = 4'h0; fdiv = 2'h0; ftick = 0; fails = 0; checks = 0; seed = 32'h106e;
		e_link = 0; e_idle = 1; e_ps = 0; e_seen = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(12'h070, 32'h0);
		xfer(1'b0, 12'h100, 32'h0, 1'b1, 32'h0);
		xfer(1'b1, 12'h104, 32'hffffffff, 1'b1, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			@(posedge clk);
			pll  <= 1'($random(seed));
			cal  <= 1'($random(seed));
			clkp <= 1'($random(seed));
			repeat (5) @(posedge clk);
			rd(12'h06c, st());
		end
		$display("test static bits done");
		pll  <= 1'b1;
		clkp <= 1'b1;
		cal  <= 1'b1;
		repeat (5) @(posedge clk);
		// Events before detection is enabled must leave both flags clear
		sysref_event(1'b1);
		rd(12'h06c, st());
		wr(12'h070, {$random(seed)} | 32'h1);
		compare("sysref_detect_enable", 32'h1, {31'h0, det_en});
		rd(12'h070, 32'h1);
		sysref_event(1'b0);
		e_seen = 1;
		rd(12'h06c, st());
		sysref_event(1'b1);
		e_ps = 1;
		rd(12'h06c, st());
		rd(12'h06c, st());
		wr(12'h06c, 32'h0);
		rd(12'h06c, st());
		wr(12'h06c, 32'hffffffe7);
		rd(12'h06c, st());
		wr(12'h06c, 32'h08);
		e_seen = 0;
		rd(12'h06c, st());
		wr(12'h06c, 32'h10);
		e_ps = 0;
		rd(12'h06c, st());
		sysref_event(1'b1);
		e_seen = 1;
		e_ps   = 1;
		rd(12'h06c, st());
		clkp <= 1'b0;
		repeat (5) @(posedge clk);
		e_seen = 0;
		e_ps   = 0;
		rd(12'h06c, st());
		clkp <= 1'b1;
		repeat (5) @(posedge clk);
		$display("test sysref flags done");
		request(4'h6, 12);
		e_idle = 0;
		rd(12'h06c, st());
		wait_idle();
		e_idle = 1;
		rd(12'h06c, st());
		@(posedge clk);
		dval <= 1'b1;
		ila  <= 1'b1;
		@(posedge clk);
		ila  <= 1'b0;
		repeat (3) @(posedge clk);
		e_link = 1;
		rd(12'h06c, st());
		dval <= 1'b0;
		repeat (3) @(posedge clk);
		e_link = 0;
		rd(12'h06c, st());
		request(4'h2, 3);
		e_idle = 0;
		rd(12'h06c, st());
		wait_idle();
		e_idle = 1;
		rd(12'h06c, st());
		$display("test sync sequence done");
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire

/* File: tb/slsf_rx_model.sv */
// Behavioural model of the link receiver that raises sync requests
`timescale 1ns/1ns
`default_nettype none

module slsf_rx_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_frame_tick,
	input  wire logic       i_go,
	input  wire logic [3:0] i_frames,
	output logic            o_sync_req_n,
	output logic            o_busy
);
	logic [3:0] left;

	// Request stands for i_frames frame ticks; callers ask for four or more,
	// a shorter hold is only used when a dropped request is wanted
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sync_req_n <= 1'b1;
			left         <= 4'h0;
		end else if (i_go && o_sync_req_n) begin
			o_sync_req_n <= 1'b0;
			left         <= i_frames;
		end else if (!o_sync_req_n && i_frame_tick) begin
			left <= left - 4'h1;
			if (left <= 4'h1) begin
				o_sync_req_n <= 1'b1;
			end
		end
	end

	// Busy while the request pin is low
	assign o_busy = !o_sync_req_n;
endmodule
`default_nettype wire
